/* File: hdl/she_engine.v */
// storage host engine: identify, custom command and link-side ports
// ===========================================================
// Overview of operation
// R1: identify strobe high in each cycle a result word is presented
// R2: identify dword-valid bit i marks 32-bit lane i valid
// R3: identify index counts 256-bit words, controller low, namespace high
// R4: identify word bus carries result data, qualified by the strobe
// R5: user keeps sixteen submission dwords stable during smart/flush request
// R6: four completion dwords taken from the returned completion entry
// R7: custom strobe qualifies 256-bit smart result words
// R8: custom dword-valid bit i marks lane i of custom word valid
// R9: custom buffer index gives position of each smart word
// R10: hard block releases its reset only after leaving reset
// R11: every hard-block port is timed by the hard block clock
// R12: config read or write with location, finished by one-cycle done
// R13: config write word with byte lane enables, bit n for byte n
// R14: every stream beat carries keep, bit i marks dword i valid
// R15: request beat moves only when valid and ready both high
// R16: outbound valid stays high without gaps through each packet
// R17: last is set only in the final beat of outbound packets
// R18: hard block holds inbound valid for whole packet, last on final
// R19: engine drives ready on each inbound stream
// R20: sideband fields valid only with their stream valid
// R21: completion beat moves only when valid and ready both high
// R22: identify controller words 0..127 precede namespace words 128..255
// R23: a result word may carry only one valid dword
// R24: config request and its fields stay stable until done
// R25: outbound fields hold while valid is high and ready low
`timescale 1ns/100ps
`include "she_map.vh"
module she_engine (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_cmd_request,
  input  wire [2:0]   i_cmd_code,
  input  wire [511:0] i_custom_sq_dwords,
  output reg          o_cmd_busy,
  output reg          o_identify_out_strobe,
  output reg  [7:0]   o_identify_out_dword_valid,
  output reg  [7:0]   o_identify_out_index,
  output reg  [255:0] o_identify_out_word,
  output reg  [127:0] o_custom_cq_dwords,
  output reg          o_custom_out_strobe,
  output reg  [7:0]   o_custom_out_dword_valid,
  output reg  [7:0]   o_custom_buf_index,
  output reg  [255:0] o_custom_out_word,
  input  wire         i_link_side_reset_n,
  input  wire         i_link_side_clock,
  input  wire         i_cfg_done_pulse,
  output wire         o_cfg_read_req,
  output wire         o_cfg_write_req,
  output wire [31:0]  o_cfg_write_word,
  output wire [3:0]   o_cfg_byte_lanes,
  output wire [9:0]   o_cfg_location,
  output wire [255:0] o_rq_out_data,
  output wire [7:0]   o_rq_out_keep,
  output wire         o_rq_out_last,
  input  wire [3:0]   i_rq_out_ready,
  output wire [61:0]  o_rq_out_side,
  output wire         o_rq_out_valid,
  input  wire [255:0] i_cq_in_data,
  input  wire [7:0]   i_cq_in_keep,
  input  wire         i_cq_in_last,
  output wire         o_cq_in_ready,
  input  wire [74:0]  i_cq_in_side,
  input  wire         i_cq_in_valid,
  output reg  [255:0] o_cc_out_data,
  output reg  [7:0]   o_cc_out_keep,
  output reg          o_cc_out_last,
  input  wire [3:0]   i_cc_out_ready,
  output reg  [32:0]  o_cc_out_side,
  output reg          o_cc_out_valid,
  input  wire [255:0] i_rc_in_data,
  input  wire [7:0]   i_rc_in_keep,
  input  wire         i_rc_in_last,
  output wire         o_rc_in_ready,
  input  wire [87:0]  i_rc_in_side,
  input  wire         i_rc_in_valid
);

  // ===========================================================
  // states
  localparam [7:0] S_LRST  = 8'h01;
  localparam [7:0] S_CFGW  = 8'h02;
  localparam [7:0] S_CFGR  = 8'h04;
  localparam [7:0] S_IDLE  = 8'h08;
  localparam [7:0] S_BEAT0 = 8'h10;
  localparam [7:0] S_BEAT1 = 8'h20;
  localparam [7:0] S_WAIT  = 8'h40;
  localparam [7:0] S_DATA  = 8'h80;

  localparam SW = 1 + 1 + 1 + 4 + 4 + 1 + 1 + 256 + 1 + 1 + 8 + 256;
  localparam BW = 62 + 1 + 8 + 256;

  // ===========================================================
  // link side sampling
  wire [SW-1:0] lnk_s;
  reg  [SW-1:0] lnk_q;
  // own valid delayed to line up with the link edge sample
  reg  [1:0]    rqv_q;

  // R11: link ports timed by hard block clock
  she_sync #(
    .W (SW)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_link_side_clock, i_link_side_reset_n, i_cfg_done_pulse,
               i_rq_out_ready, i_cc_out_ready, i_cq_in_valid,
               i_cq_in_last, i_cq_in_data, i_rc_in_valid, i_rc_in_last,
               i_rc_in_keep, i_rc_in_data}),
    .o_q     (lnk_s)
  );

  // values one cycle before the seen edge are those the edge captured
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lnk_q  <= {SW{1'b0}};
      rqv_q  <= 2'h0;
    end else begin
      lnk_q  <= lnk_s;
      rqv_q  <= {rqv_q[0], o_rq_out_valid};
    end
  end

  wire         tick      = lnk_s[SW-1] & ~lnk_q[SW-1];
  wire         lrst_n_q  = lnk_q[SW-2];
  wire         done_q    = lnk_q[SW-3];
  wire [3:0]   rq_rdy_q  = lnk_q[SW-4:SW-7];
  wire [3:0]   cc_rdy_q  = lnk_q[SW-8:SW-11];
  wire         cq_vld_q  = lnk_q[SW-12];
  wire         cq_last_q = lnk_q[SW-13];
  wire [31:0]  cq_dw0_q  = lnk_q[SW-14-224:SW-13-256];
  wire         rc_vld_q  = lnk_q[265];
  wire         rc_last_q = lnk_q[264];
  wire [7:0]   rc_keep_q = lnk_q[263:256];
  wire [255:0] rc_data_q = lnk_q[255:0];

  // ===========================================================
  // command engine
  reg [7:0]   state_reg;
  reg [2:0]   cmd_reg;
  reg [511:0] sq_reg;
  reg [7:0]   cnt_reg;

  wire          buf_in_valid = (state_reg == S_BEAT0) |
                               (state_reg == S_BEAT1);
  wire          buf_in_ready;
  wire          second       = (state_reg == S_BEAT1);
  wire [BW-1:0] buf_in_data;
  wire [BW-1:0] buf_out_data;
  wire          rq_pop       = tick & rqv_q[1] & (|rq_rdy_q);

  // R14: every request beat is fully kept
  // R17: last only on the second beat
  assign buf_in_data = {62'h0, second, `SHE_KEEP_ALL,
                        second ? sq_reg[511:256] : sq_reg[255:0]};

  // R15: pop only when the edge saw valid and ready
  // R25: buffer head stays until popped
  she_buf2 #(
    .W     (BW),
    .DEPTH (2),
    .AW    (1)
  ) u_rqbuf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (buf_in_valid),
    .o_ready (buf_in_ready),
    .i_data  (buf_in_data),
    .o_valid (o_rq_out_valid),
    .i_ready (rq_pop),
    .o_data  (buf_out_data)
  );

  // R20: side field zero and only meaningful with valid
  assign o_rq_out_side = buf_out_data[BW-1:BW-62];
  assign o_rq_out_last = buf_out_data[264];
  assign o_rq_out_keep = buf_out_data[263:256];
  assign o_rq_out_data = buf_out_data[255:0];

  // R12: request level straight from the state flop
  // R24: fields are constant per state, held until done
  // R13: one lane enabled for the write word
  assign o_cfg_write_req  = (state_reg == S_CFGW);
  assign o_cfg_read_req   = (state_reg == S_CFGR);
  assign o_cfg_location   = o_cfg_read_req ? `SHE_CFG_RD_LOC
                                           : `SHE_CFG_WR_LOC;
  assign o_cfg_write_word = `SHE_CFG_WR_WORD;
  assign o_cfg_byte_lanes = `SHE_CFG_WR_LANES;

  // R19: ready on both inbound streams
  assign o_rc_in_ready = (state_reg == S_DATA);
  assign o_cq_in_ready = ~o_cc_out_valid;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg                  <= S_LRST;
      cmd_reg                    <= 3'h0;
      sq_reg                     <= 512'h0;
      cnt_reg                    <= 8'h00;
      o_cmd_busy                 <= 1'b1;
      o_identify_out_strobe      <= 1'b0;
      o_identify_out_dword_valid <= 8'h00;
      o_identify_out_index       <= 8'h00;
      o_identify_out_word        <= 256'h0;
      o_custom_cq_dwords         <= 128'h0;
      o_custom_out_strobe        <= 1'b0;
      o_custom_out_dword_valid   <= 8'h00;
      o_custom_buf_index         <= 8'h00;
      o_custom_out_word          <= 256'h0;
    end else begin
      o_identify_out_strobe <= 1'b0;
      o_custom_out_strobe   <= 1'b0;
      case (state_reg)
        S_LRST: begin
          // R10: start only once hard block is out of reset
          if (tick && lrst_n_q) begin
            state_reg <= S_CFGW;
          end
        end
        S_CFGW: begin
          // R12: done seen at exactly one edge
          if (tick && done_q) begin
            state_reg <= S_CFGR;
          end
        end
        S_CFGR: begin
          if (tick && done_q) begin
            state_reg  <= S_IDLE;
            o_cmd_busy <= 1'b0;
          end
        end
        S_IDLE: begin
          // R5: submission dwords captured while request is high
          if (i_cmd_request && (i_cmd_code == `SHE_CMD_IDENT ||
              i_cmd_code == `SHE_CMD_SMART ||
              i_cmd_code == `SHE_CMD_FLUSH)) begin
            cmd_reg    <= i_cmd_code;
            sq_reg     <= (i_cmd_code == `SHE_CMD_IDENT) ?
                          {504'h0, `SHE_OPC_IDENT} : i_custom_sq_dwords;
            cnt_reg    <= 8'h00;
            o_cmd_busy <= 1'b1;
            state_reg  <= S_BEAT0;
          end
        end
        S_BEAT0: begin
          // R16: both beats queued back to back, no gap
          if (buf_in_ready) begin
            state_reg <= S_BEAT1;
          end
        end
        S_BEAT1: begin
          if (buf_in_ready) begin
            state_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (!o_rq_out_valid) begin
            state_reg <= S_DATA;
          end
        end
        S_DATA: begin
          // R18: trusts hard block to keep valid through each packet
          if (tick && rc_vld_q) begin
            if (cmd_reg == `SHE_CMD_IDENT) begin
              // R1: one strobe per word
              // R2: lane enables taken from keep
              // R23: single-dword words pass through as received
              // R3: index counts words
              // R4: word from the completion beat
              o_identify_out_strobe      <= 1'b1;
              o_identify_out_dword_valid <= rc_keep_q;
              o_identify_out_index       <= cnt_reg;
              o_identify_out_word        <= rc_data_q;
              cnt_reg                    <= cnt_reg + 8'h01;
              // R22: controller words first, namespace after
              if (cnt_reg == `SHE_IDENT_LAST) begin
                state_reg  <= S_IDLE;
                o_cmd_busy <= 1'b0;
              end
            end else if (cmd_reg == `SHE_CMD_SMART &&
                         cnt_reg != `SHE_SMART_WORDS) begin
              // R7: smart word on the custom bus
              // R8: custom lane enables from keep
              // R9: buffer index per word
              o_custom_out_strobe      <= 1'b1;
              o_custom_out_dword_valid <= rc_keep_q;
              o_custom_buf_index       <= cnt_reg;
              o_custom_out_word        <= rc_data_q;
              cnt_reg                  <= cnt_reg + 8'h01;
            end else begin
              // R6: completion entry ends smart or flush
              o_custom_cq_dwords <= rc_data_q[127:0];
              state_reg          <= S_IDLE;
              o_cmd_busy         <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= S_LRST;
        end
      endcase
      // R10: hard block reset aborts and restarts setup
      if (tick && !lrst_n_q) begin
        state_reg  <= S_LRST;
        o_cmd_busy <= 1'b1;
      end
    end
  end

  // ===========================================================
  // completer side: one single-beat completion per inbound packet
  // non-last beats are swallowed; only the first dword is echoed
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cc_out_valid <= 1'b0;
      o_cc_out_data  <= 256'h0;
      o_cc_out_keep  <= 8'h00;
      o_cc_out_last  <= 1'b0;
      o_cc_out_side  <= 33'h0;
    end else if (tick) begin
      // R21: cleared only when edge saw valid and ready
      // R25: fields held otherwise
      if (o_cc_out_valid) begin
        if (|cc_rdy_q) begin
          o_cc_out_valid <= 1'b0;
        end
      end else if (cq_vld_q && cq_last_q) begin
        // R17: single beat, so it is also the last
        // R14: keep marks the one valid dword
        o_cc_out_valid <= 1'b1;
        o_cc_out_data  <= {224'h0, cq_dw0_q};
        o_cc_out_keep  <= `SHE_KEEP_ONE;
        o_cc_out_last  <= 1'b1;
        o_cc_out_side  <= 33'h0;
      end
    end
  end

endmodule // she_engine

/* File: hdl/she_map.vh */
// constants shared by the storage host engine files
`ifndef SHE_MAP_VH
`define SHE_MAP_VH

// ===========================================================
// user command codes
`define SHE_CMD_IDENT      3'h0
`define SHE_CMD_SMART      3'h4
`define SHE_CMD_FLUSH      3'h6

// ===========================================================
// submission descriptor for identify
`define SHE_OPC_IDENT      8'h06

// ===========================================================
// configuration access made after link reset release
`define SHE_CFG_WR_LOC     10'h001
`define SHE_CFG_WR_WORD    32'h00000006
`define SHE_CFG_WR_LANES   4'h1
`define SHE_CFG_RD_LOC     10'h000

// ===========================================================
// result counts, in 256-bit words
`define SHE_IDENT_LAST     8'hff
`define SHE_SMART_WORDS    8'h10

// ===========================================================
// outbound stream fixed fields
`define SHE_KEEP_ALL       8'hff
`define SHE_KEEP_ONE       8'h01

`endif

/* File: hdl/she_sync.v */
// two flip-flop synchroniser, any width
`timescale 1ns/100ps
module she_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;

endmodule // she_sync

/* File: hdl/she_buf2.v */
// small valid/ready buffer, two entries by default
`timescale 1ns/100ps
module she_buf2 #(
  parameter W     = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0]   cnt_reg;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_valid = (cnt_reg != {(AW+1){1'b0}});
  assign o_data  = mem[rd_reg];

  always @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_reg  <= {AW{1'b0}};
      rd_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                  : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                  : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // she_buf2

/* File: testbench/she_engine_props.sv */
// assertion checker for the storage host engine ports
`timescale 1ns/100ps
`include "she_map.vh"
module she_engine_props (
  input wire         i_clk,
  input wire         i_rst_n,
  input wire         o_cmd_busy,
  input wire         o_identify_out_strobe,
  input wire [7:0]   o_identify_out_index,
  input wire         o_custom_out_strobe,
  input wire [7:0]   o_custom_buf_index,
  input wire         i_cfg_done_pulse,
  input wire         o_cfg_read_req,
  input wire         o_cfg_write_req,
  input wire [31:0]  o_cfg_write_word,
  input wire [3:0]   o_cfg_byte_lanes,
  input wire [9:0]   o_cfg_location,
  input wire [255:0] o_rq_out_data,
  input wire         o_rq_out_last,
  input wire         o_rq_out_valid,
  input wire [3:0]   i_rq_out_ready,
  input wire         o_cc_out_valid,
  input wire [7:0]   o_cc_out_keep,
  input wire         o_cc_out_last
);
  // ===========================================================
  // helper counters
  reg [7:0] idx_reg;
  reg [3:0] idle_reg;
  reg [3:0] done_age_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_reg <= 8'h00;
      idle_reg <= 4'h0;
      done_age_reg <= 4'hf;
    end else begin
      if (o_identify_out_strobe)
        idx_reg <= o_identify_out_index + 8'h01;
      if (i_rq_out_ready != 4'h0)
        idle_reg <= 4'h0;
      else if (idle_reg != 4'hf)
        idle_reg <= idle_reg + 4'h1;
      if (i_cfg_done_pulse)
        done_age_reg <= 4'h0;
      else if (done_age_reg != 4'hf)
        done_age_reg <= done_age_reg + 4'h1;
    end
  end
  // ===========================================================
  // properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_last_word;
    o_identify_out_strobe && o_identify_out_index == `SHE_IDENT_LAST;
  endsequence
  sequence s_rq_drop;
    o_rq_out_valid ##1 !o_rq_out_valid;
  endsequence
  a_iden_pulse: assert property (
    o_identify_out_strobe |=> !o_identify_out_strobe)
    else $error("identify strobe held over one cycle");
  a_iden_index: assert property (
    o_identify_out_strobe |-> o_identify_out_index == idx_reg)
    else $error("identify index out of sequence");
  a_iden_end: assert property (
    s_last_word |-> ##[0:2] !o_cmd_busy)
    else $error("busy stayed after last identify word");
  a_ctm_index: assert property (
    o_custom_out_strobe |-> o_custom_buf_index < `SHE_SMART_WORDS)
    else $error("custom index beyond smart data");
  a_cfg_one_kind: assert property (
    !(o_cfg_read_req && o_cfg_write_req))
    else $error("config read and write together");
  a_cfg_fields: assert property (
    o_cfg_write_req |-> o_cfg_byte_lanes == `SHE_CFG_WR_LANES &&
      o_cfg_write_word == `SHE_CFG_WR_WORD &&
      o_cfg_location == `SHE_CFG_WR_LOC)
    else $error("config write fields wrong");
  a_cfg_until_done: assert property (
    $fell(o_cfg_write_req) || $fell(o_cfg_read_req) |-> done_age_reg < 4'h8)
    else $error("config request dropped without done");
  a_rq_hold: assert property (
    o_rq_out_valid && $past(o_rq_out_valid) && idle_reg > 4'h6 |->
      $stable(o_rq_out_data) && $stable(o_rq_out_last))
    else $error("request beat changed while stalled");
  a_rq_no_gap: assert property (
    s_rq_drop |-> $past(o_rq_out_last))
    else $error("request valid dropped inside packet");
  a_cc_beat: assert property (
    o_cc_out_valid |-> o_cc_out_last && o_cc_out_keep == `SHE_KEEP_ONE)
    else $error("completion beat keep or last wrong");
endmodule // she_engine_props

bind she_engine she_engine_props u_she_engine_props (.*);

/* File: testbench/she_hard_model.sv */
// far-side model: link clock and reset, config and packet streams
`timescale 1ns/100ps
module she_hard_model (
  output reg         o_lclk,
  output reg         o_lrst_n,
  output reg         o_cfg_done,
  input  wire        i_cfg_rd,
  input  wire        i_cfg_wr,
  input  wire [255:0] i_rq_data,
  input  wire [7:0]  i_rq_keep,
  input  wire        i_rq_last,
  input  wire        i_rq_valid,
  output reg  [3:0]  o_rq_ready,
  output reg  [255:0] o_cq_data,
  output reg         o_cq_valid,
  input  wire        i_cq_ready,
  input  wire [255:0] i_cc_data,
  input  wire        i_cc_valid,
  output reg  [3:0]  o_cc_ready,
  output reg  [255:0] o_rc_data,
  output reg  [7:0]  o_rc_keep,
  output reg         o_rc_last,
  output reg         o_rc_valid,
  input  wire        i_rc_ready
);
  // set and read by the bench
  reg         stall = 1'b0;
  reg         hold = 1'b1;
  reg         cq_go = 1'b0;
  reg [31:0]  tag = 32'h0;
  reg [255:0] cc_word = 256'h0;
  reg [255:0] rq_beat [0:1];
  integer     nbeats = 0, left = 0, sent = 0, rqn = 0, rq_bad = 0;
  integer     cc_cnt = 0, cfg_cnt = 0, cfg_log = 0;
  initial begin
    {o_lclk, o_lrst_n, o_cfg_done, o_cq_valid, o_rc_valid} = 5'h00;
    {o_rq_ready, o_cc_ready, o_rc_keep, o_rc_last} = 17'h0;
    o_cq_data = 256'h0;
    o_rc_data = 256'h0;
    // odd offset keeps link edges off the system clock edges, at a fixed phase
    #7;
    forever #160 o_lclk = ~o_lclk;
  end
  always @(posedge o_lclk) begin
    o_lrst_n <= !hold;
    o_rq_ready <= stall ? 4'h0 : 4'h2;
    o_cc_ready <= stall ? 4'h0 : 4'h8;
    o_cfg_done <= 1'b0;
    if (cfg_cnt != 0) begin
      cfg_cnt <= cfg_cnt - 1;
      o_cfg_done <= cfg_cnt == 1;
    end else if ((i_cfg_wr || i_cfg_rd) && !o_cfg_done) begin
      cfg_cnt <= 2;
      cfg_log <= cfg_log * 2 + i_cfg_rd;
    end
    // beat taken with valid and ready
    if (i_rq_valid && o_rq_ready != 4'h0) begin
      rq_beat[rqn] <= i_rq_data;
      if (i_rq_keep != 8'hff || i_rq_last != (rqn == 1))
        rq_bad <= rq_bad + 1;
      rqn <= i_rq_last ? 0 : 1;
      if (i_rq_last) begin
        left <= nbeats;
        sent <= 0;
      end
    end
    // valid held through packet, last on final
    if (!(o_rc_valid && !i_rc_ready)) begin
      if (left != 0) begin
        o_rc_valid <= 1'b1;
        o_rc_data <= {8{tag ^ sent}};
        o_rc_keep <= (sent % 4 == 3) ? 8'h01 << (sent % 8) : 8'hff;
        o_rc_last <= left == 1;
        left <= left - 1;
        sent <= sent + 1;
      end else begin
        o_rc_valid <= 1'b0;
        o_rc_data <= ~o_rc_data;
      end
    end
    if (o_cq_valid && i_cq_ready) begin
      o_cq_valid <= 1'b0;
      o_cq_data <= ~o_cq_data;
    end else if (cq_go && !o_cq_valid) begin
      o_cq_valid <= 1'b1;
      o_cq_data <= {8{tag}};
      cq_go <= 1'b0;
    end
    // completion taken with valid and ready
    if (i_cc_valid && o_cc_ready != 4'h0) begin
      cc_cnt <= cc_cnt + 1;
      cc_word <= i_cc_data;
    end
  end
endmodule // she_hard_model

/* File: testbench/test_she_engine.sv */
// self-checking bench for the storage host engine
`timescale 1ns/100ps
`include "she_map.vh"
module test_she_engine;
  reg          i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_request = 1'b0;
  reg  [2:0]   i_cmd_code = 3'h0;
  reg  [511:0] i_custom_sq_dwords = 512'h0;
  wire         o_cmd_busy, o_identify_out_strobe, o_custom_out_strobe;
  wire         i_link_side_reset_n, i_link_side_clock, i_cfg_done_pulse;
  wire         o_cfg_read_req, o_cfg_write_req, o_rq_out_last, i_cq_in_last;
  wire         o_rq_out_valid, o_cq_in_ready, i_cq_in_valid, o_cc_out_last;
  wire         o_cc_out_valid, i_rc_in_last, o_rc_in_ready, i_rc_in_valid;
  wire [7:0]   o_identify_out_dword_valid, o_identify_out_index;
  wire [7:0]   o_custom_out_dword_valid, o_custom_buf_index;
  wire [7:0]   o_rq_out_keep, o_cc_out_keep, i_rc_in_keep;
  wire [255:0] o_identify_out_word, o_custom_out_word, o_rq_out_data;
  wire [255:0] i_cq_in_data, o_cc_out_data, i_rc_in_data;
  wire [127:0] o_custom_cq_dwords;
  wire [31:0]  o_cfg_write_word;
  wire [3:0]   o_cfg_byte_lanes, i_rq_out_ready, i_cc_out_ready;
  wire [9:0]   o_cfg_location;
  wire [61:0]  o_rq_out_side;
  wire [32:0]  o_cc_out_side;
  wire [7:0]   i_cq_in_keep = 8'h01;
  wire [74:0]  i_cq_in_side = 75'h0;
  wire [87:0]  i_rc_in_side = 88'h0;
  // inbound requests are single beats
  assign i_cq_in_last = i_cq_in_valid;
  she_engine u_she_engine (.*);
  she_hard_model u_she_hard_model (
    .o_lclk(i_link_side_clock), .o_lrst_n(i_link_side_reset_n),
    .o_cfg_done(i_cfg_done_pulse), .i_cfg_rd(o_cfg_read_req),
    .i_cfg_wr(o_cfg_write_req), .i_rq_data(o_rq_out_data),
    .i_rq_keep(o_rq_out_keep), .i_rq_last(o_rq_out_last),
    .i_rq_valid(o_rq_out_valid), .o_rq_ready(i_rq_out_ready),
    .o_cq_data(i_cq_in_data), .o_cq_valid(i_cq_in_valid),
    .i_cq_ready(o_cq_in_ready), .i_cc_data(o_cc_out_data),
    .i_cc_valid(o_cc_out_valid), .o_cc_ready(i_cc_out_ready),
    .o_rc_data(i_rc_in_data), .o_rc_keep(i_rc_in_keep),
    .o_rc_last(i_rc_in_last), .o_rc_valid(i_rc_in_valid),
    .i_rc_ready(o_rc_in_ready));
  // ===========================================================
  // checking and model
  integer     mismatches = 0, checked = 0, ik = 0, ck = 0, k, t;
  reg [31:0]  rng = 32'h42, tg = 32'h0;
  reg [263:0] rc_q [$];
  reg [263:0] e;
  always #20 i_clk = ~i_clk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  function [263:0] beat(input integer n);
    beat = {(n % 4 == 3) ? 8'h01 << (n % 8) : 8'hff, {8{tg ^ n}}};
  endfunction
  task check(input [255:0] seen, input [255:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task wait_idle;
    begin
      t = 0;
      while (o_cmd_busy !== 1'b0 && t < 6000) begin
        @(posedge i_clk);
        t = t + 1;
      end
      check(t < 6000, 1'b1);
      #2;
    end
  endtask
  // dwords stable while the request is up
  task run_cmd(input [2:0] code, input integer n, input integer ns);
    begin
      rng = xs(rng);
      tg = rng;
      u_she_hard_model.tag = tg;
      u_she_hard_model.nbeats = n;
      for (k = 0; k < ns; k = k + 1)
        rc_q.push_back(beat(k));
      ik = 0;
      ck = 0;
      i_cmd_code = code;
      i_cmd_request = 1'b1;
      @(posedge i_clk);
      #2;
      check(o_cmd_busy, 1'b1);
      i_cmd_request = 1'b0;
      wait_idle;
      check(rc_q.size(), 0);
      check(u_she_hard_model.rq_bad, 0);
      e = beat(n - 1);
      if (code != `SHE_CMD_IDENT) begin
        check(o_custom_cq_dwords, e[127:0]);
        check(u_she_hard_model.rq_beat[0], i_custom_sq_dwords[255:0]);
        check(u_she_hard_model.rq_beat[1], i_custom_sq_dwords[511:256]);
      end
    end
  endtask
  always @(negedge i_clk) begin
    if (o_identify_out_strobe === 1'b1) begin
      e = rc_q.pop_front();
      check(o_identify_out_index, ik);
      check(o_identify_out_dword_valid, e[263:256]);
      check(o_identify_out_word, e[255:0]);
      ik = ik + 1;
    end
    if (o_custom_out_strobe === 1'b1) begin
      e = rc_q.pop_front();
      check(o_custom_buf_index, ck);
      check(o_custom_out_dword_valid, e[263:256]);
      check(o_custom_out_word, e[255:0]);
      ck = ck + 1;
    end
  end
  // random stalls on both outbound streams
  always @(posedge i_clk) begin
    #2;
    rng = xs(rng);
    u_she_hard_model.stall = rng[0] & rng[1];
  end
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  // ===========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge i_clk);
    #2;
    check(o_cmd_busy, 1'b1);
    i_rst_n = 1'b1;
    u_she_hard_model.hold = 1'b0;
    wait_idle;
    check(u_she_hard_model.cfg_log, 1);
    run_cmd(`SHE_CMD_IDENT, 256, 256);
    check(ik, 256);
    for (k = 0; k < 16; k = k + 1) begin
      rng = xs(rng);
      i_custom_sq_dwords[k*32 +: 32] = rng;
    end
    run_cmd(`SHE_CMD_SMART, 17, 16);
    check(ck, 16);
    run_cmd(`SHE_CMD_FLUSH, 1, 0);
    i_cmd_code = 3'h2;
    i_cmd_request = 1'b1;
    repeat (3) @(posedge i_clk);
    #2;
    i_cmd_request = 1'b0;
    check(o_cmd_busy, 1'b0);
    u_she_hard_model.cq_go = 1'b1;
    t = 0;
    while (u_she_hard_model.cc_cnt != 1 && t < 400) begin
      @(posedge i_clk);
      t = t + 1;
    end
    check(u_she_hard_model.cc_word, {224'h0, tg});
    u_she_hard_model.hold = 1'b1;
    #1400;
    check(o_cmd_busy, 1'b1);
    u_she_hard_model.hold = 1'b0;
    wait_idle;
    check(u_she_hard_model.cfg_log, 5);
    wrap_up;
  end
endmodule // test_she_engine
